/* shared/lfrc_pkg.sv */
// Shared constants for the low-frequency real-time counter
package lfrc_pkg;
	// System and low-frequency clock rates
	localparam int unsigned CLK_SYS_HZ   = 200_000_000;
	localparam int unsigned LF_CLOCK_HZ  = 32_768;
	localparam int unsigned LF_HALF_CYC  = CLK_SYS_HZ / (2 * LF_CLOCK_HZ);
	localparam int          LF_HALF_W    = 12;
	// Task delay and start figures, in nanoseconds as printed
	localparam int unsigned TASK_DLY_MIN_NS = 15_259;
	localparam int unsigned TASK_DLY_MAX_NS = 45_776;
	localparam int unsigned START_TYP_NS    = 30_500;
	localparam int unsigned CLK_STABLE_NS   = 250_000;

	// Widths
	localparam int COUNT_W = 24;
	localparam int DIV_W   = 12;
	localparam int NUM_CMP = 4;
	localparam int NUM_EV  = 2 + NUM_CMP;

	// Counter values
	localparam logic [COUNT_W-1:0] COUNT_RESET   = 24'h000000;
	localparam logic [COUNT_W-1:0] COUNT_MAX     = 24'hffffff;
	localparam logic [COUNT_W-1:0] COUNT_NEAR_WR = 24'hfffff0;
	localparam logic [DIV_W-1:0]   DIV_RESET     = 12'h000;
	localparam logic [DIV_W-1:0]   CD_ZERO       = 12'h000;

	// Read-stall for a counter read (cycles of hreadyout low)
	localparam logic [1:0] CNT_RD_WAIT = 2'h3;

	// Register byte offsets
	localparam logic [11:0] OFS_TASK_START = 12'h000;
	localparam logic [11:0] OFS_TASK_STOP  = 12'h004;
	localparam logic [11:0] OFS_TASK_CLEAR = 12'h008;
	localparam logic [11:0] OFS_TASK_FNW   = 12'h00c;
	localparam logic [11:0] OFS_EV_TICK    = 12'h100;
	localparam logic [11:0] OFS_EV_WRAP    = 12'h104;
	localparam logic [11:0] OFS_EV_CMP0    = 12'h140;
	localparam logic [11:0] OFS_INTENSET   = 12'h304;
	localparam logic [11:0] OFS_INTENCLR   = 12'h308;
	localparam logic [11:0] OFS_EVENT_ROUTE_ENABLE      = 12'h340;
	localparam logic [11:0] OFS_EVTENSET   = 12'h344;
	localparam logic [11:0] OFS_EVTENCLR   = 12'h348;
	localparam logic [11:0] OFS_COUNTER    = 12'h504;
	localparam logic [11:0] OFS_DIVIDER    = 12'h508;
	localparam logic [11:0] OFS_CMP0       = 12'h540;

	// Field positions in enable registers
	localparam int BIT_TICK = 0;
	localparam int BIT_WRAP = 1;
	localparam int BIT_CMP0 = 16;

	// Event vector positions
	localparam int EV_TICK = 0;
	localparam int EV_WRAP = 1;
	localparam int EV_CMP0 = 2;

	// Task index in pending vectors
	localparam int TK_STOP  = 0;
	localparam int TK_CLEAR = 1;
	localparam int TK_FNW   = 2;

	typedef enum logic [1:0] {
		ST_STOPPED  = 2'b00,
		ST_STARTING = 2'b01,
		ST_RUNNING  = 2'b11
	} lfrc_state_e;
endpackage

/* hw/lfrc_lf_tick.sv */
// Low-frequency clock edge enables derived from the system clock
`timescale 1ns/1ps
module lfrc_lf_tick (
	input  wire logic clk_sys_in,
	input  wire logic rst_in,
	input  wire logic run_in,
	output logic      rise_en_out,
	output logic      fall_en_out
);
	import lfrc_pkg::*;

	localparam logic [LF_HALF_W-1:0] HALF_LAST = LF_HALF_W'(LF_HALF_CYC - 1);

	logic [LF_HALF_W-1:0] cnt_q;
	logic                 level_q;

	// Clock stands still while not running, so no edge leaks out
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q   <= '0;
			level_q <= 1'b0;
		end else if (!run_in) begin
			cnt_q   <= '0;
			level_q <= 1'b0;
		end else if (cnt_q == HALF_LAST) begin
			cnt_q   <= '0;
			level_q <= ~level_q;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	assign rise_en_out = run_in && (cnt_q == HALF_LAST) && !level_q;
	assign fall_en_out = run_in && (cnt_q == HALF_LAST) && level_q;
endmodule

/* hw/lfrc_top.sv */
// Low-frequency real-time counter with AHB-Lite register slave
`timescale 1ns/1ps

module lfrc_top (
	input  wire logic                          clk_sys_in,
	input  wire logic                          rst_in,
	// AHB-Lite slave
	input  wire logic                          hsel_in,
	input  wire logic [31:0]                   haddr_in,
	input  wire logic [1:0]                    htrans_in,
	input  wire logic                          hwrite_in,
	input  wire logic [2:0]                    hsize_in,
	input  wire logic [31:0]                   hwdata_in,
	input  wire logic                          hready_in,
	output logic      [31:0]                   hrdata_out,
	output logic                               hreadyout_out,
	output logic                               hresp_out,
	// Low-frequency clock control
	input  wire logic                          low_freq_clock_stable_in,
	output logic                               low_freq_clock_request_out,
	// Routed events and fast clock request
	output logic      [lfrc_pkg::NUM_EV-1:0]   event_out,
	output logic                               fast_clock_request_out,
	output logic                               event_irq_out
);
	import lfrc_pkg::*;

	// Map event vector to enable register layout and back
	function automatic logic [31:0] ev_to_reg(input logic [NUM_EV-1:0] ev);
		logic [31:0] r;
		r = '0;
		r[BIT_TICK] = ev[EV_TICK];
		r[BIT_WRAP] = ev[EV_WRAP];
		r[BIT_CMP0 +: NUM_CMP] = ev[EV_CMP0 +: NUM_CMP];
		return r;
	endfunction

	function automatic logic [NUM_EV-1:0] reg_to_ev(input logic [31:0] r);
		logic [NUM_EV-1:0] ev;
		ev = '0;
		ev[EV_TICK] = r[BIT_TICK];
		ev[EV_WRAP] = r[BIT_WRAP];
		ev[EV_CMP0 +: NUM_CMP] = r[BIT_CMP0 +: NUM_CMP];
		return ev;
	endfunction

	// Low-frequency edge enables
	logic lf_rise;
	logic lf_fall;
	logic lf_run;

	assign lf_run = low_freq_clock_stable_in;

	lfrc_lf_tick u_lf_tick (
		.clk_sys_in  (clk_sys_in),
		.rst_in      (rst_in),
		.run_in      (lf_run),
		.rise_en_out (lf_rise),
		.fall_en_out (lf_fall)
	);

	// Bus address phase
	logic        ap_valid;
	logic        dp_wr_q;
	logic [11:0] dp_addr_q;
	logic [1:0]  wait_q;
	logic [31:0] rdata_q;
	logic [31:0] rd_mux;

	assign ap_valid = hsel_in && htrans_in[1] && hready_in;

	// Control and state registers
	lfrc_state_e          state_q;
	logic [COUNT_W-1:0]   count_q;
	logic [DIV_W-1:0]     divider_q;
	logic [DIV_W-1:0]     divider_countdown_q;
	logic [COUNT_W-1:0]   compare_value_q [NUM_CMP];
	logic [NUM_EV-1:0]    event_route_enable_q;
	logic [NUM_EV-1:0]    int_en_q;
	logic [NUM_EV-1:0]    ev_flag_q;
	logic                 start_pend_q;
	logic [2:0]           task_pend_q;
	logic [2:0]           fall_seen_q;

	// Data-phase write decode
	logic                 wr_start;
	logic                 wr_stop;
	logic                 wr_clear;
	logic                 wr_fnw;
	logic                 wr_div;
	logic [NUM_CMP-1:0]   wr_cmp;
	logic                 wr_go;

	assign wr_go    = dp_wr_q && hwdata_in[0];
	assign wr_start = wr_go && (dp_addr_q == OFS_TASK_START);
	assign wr_stop  = wr_go && (dp_addr_q == OFS_TASK_STOP);
	assign wr_clear = wr_go && (dp_addr_q == OFS_TASK_CLEAR);
	assign wr_fnw   = wr_go && (dp_addr_q == OFS_TASK_FNW);
	assign wr_div   = dp_wr_q && (dp_addr_q == OFS_DIVIDER)
	                  && (state_q == ST_STOPPED) && !start_pend_q;

	always_comb begin
		for (int i = 0; i < NUM_CMP; i++) begin
			wr_cmp[i] = dp_wr_q && (dp_addr_q == OFS_CMP0 + 12'(4 * i));
		end
	end

	// Task application on low-frequency edges
	logic apply_stop;
	logic apply_clear;
	logic apply_fnw;
	logic apply_start;
	logic incr;
	logic [COUNT_W-1:0] count_next;

	// a falling then a rising edge before the task acts
	assign apply_stop  = lf_rise && task_pend_q[TK_STOP]  && fall_seen_q[TK_STOP];
	assign apply_clear = lf_rise && task_pend_q[TK_CLEAR] && fall_seen_q[TK_CLEAR];
	assign apply_fnw   = lf_rise && task_pend_q[TK_FNW]   && fall_seen_q[TK_FNW];
	// start arms on next falling edge
	// Falling arm puts first step half to one and a half periods out
	assign apply_start = lf_fall && start_pend_q;

	// step only when countdown is zero
	assign incr = lf_rise && (state_q == ST_RUNNING) && (divider_countdown_q == CD_ZERO)
	              && !apply_stop && !apply_clear && !apply_fnw;
	assign count_next = count_q + 1'b1;

	// Pending tasks: set on write, cleared when applied; a stop write also drops a pending start
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			task_pend_q  <= '0;
			fall_seen_q  <= '0;
			start_pend_q <= 1'b0;
		end else begin
			for (int t = 0; t < 3; t++) begin
				logic wr_t;
				logic ap_t;
				wr_t = (t == TK_STOP) ? wr_stop : (t == TK_CLEAR) ? wr_clear : wr_fnw;
				ap_t = (t == TK_STOP) ? apply_stop : (t == TK_CLEAR) ? apply_clear : apply_fnw;
				if (wr_t) begin
					task_pend_q[t] <= 1'b1;
					fall_seen_q[t] <= 1'b0;
				end else if (ap_t) begin
					task_pend_q[t] <= 1'b0;
					fall_seen_q[t] <= 1'b0;
				end else if (lf_fall && task_pend_q[t]) begin
					fall_seen_q[t] <= 1'b1;
				end
			end
			if (wr_start) begin
				start_pend_q <= 1'b1;
			end else if (apply_start || wr_stop) begin
				start_pend_q <= 1'b0;
			end
		end
	end

	// clock requested while a near-wrap load waits for it
	assign low_freq_clock_request_out = task_pend_q[TK_FNW] && !low_freq_clock_stable_in;

	// Run state
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= ST_STOPPED;
		end else if (wr_start) begin
			state_q <= ST_STARTING;
		end else if (apply_stop) begin
			state_q <= ST_STOPPED;
		end else if (apply_start && state_q == ST_STARTING) begin
			state_q <= ST_RUNNING;
		end
	end

	// Counter and divider countdown
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			count_q             <= COUNT_RESET;
			divider_countdown_q <= DIV_RESET;
		end else if (apply_clear) begin
			count_q             <= COUNT_RESET;
			divider_countdown_q <= divider_q;
		end else if (apply_fnw) begin
			count_q             <= COUNT_NEAR_WR;
			divider_countdown_q <= divider_q;
		end else if (wr_start) begin
			divider_countdown_q <= divider_q;
		end else if (incr) begin
			// one step per divider+1 low-frequency rising edges
			count_q             <= count_next;
			divider_countdown_q <= divider_q;
		end else if (lf_rise && state_q == ST_RUNNING) begin
			divider_countdown_q <= divider_countdown_q - 1'b1;
		end
	end

	// Raw events; compares only fire on a real step
	logic [NUM_EV-1:0] ev_raw;
	logic [NUM_EV-1:0] ev_on;

	always_comb begin
		ev_raw = '0;
		ev_raw[EV_TICK] = incr;
		ev_raw[EV_WRAP] = incr && (count_q == COUNT_MAX);
		for (int i = 0; i < NUM_CMP; i++) begin
			// match only on N-1 to N step
			ev_raw[EV_CMP0 + i] = incr && (count_next == compare_value_q[i]);
		end
	end

	// route enable gates the event; route or interrupt enable gates its fast clock request
	assign ev_on                  = ev_raw & (event_route_enable_q | int_en_q);
	assign event_out              = ev_raw & event_route_enable_q;
	assign fast_clock_request_out = |ev_on;
	assign event_irq_out          = |(ev_flag_q & int_en_q);

	// Sticky event flags; set wins over a software clear
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			ev_flag_q <= '0;
		end else begin
			for (int e = 0; e < NUM_EV; e++) begin
				logic [11:0] fa;
				fa = (e == EV_TICK) ? OFS_EV_TICK :
				     (e == EV_WRAP) ? OFS_EV_WRAP : OFS_EV_CMP0 + 12'(4 * (e - EV_CMP0));
				if (ev_on[e]) begin
					ev_flag_q[e] <= 1'b1;
				end else if (dp_wr_q && dp_addr_q == fa) begin
					ev_flag_q[e] <= hwdata_in[0];
				end
			end
		end
	end

	// Enables, divider and compare values
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			event_route_enable_q <= '0;
			int_en_q             <= '0;
			divider_q            <= DIV_RESET;
			for (int i = 0; i < NUM_CMP; i++) begin
				compare_value_q[i] <= COUNT_RESET;
			end
		end else if (dp_wr_q) begin
			unique case (dp_addr_q)
				OFS_EVENT_ROUTE_ENABLE:    event_route_enable_q <= reg_to_ev(hwdata_in);
				OFS_EVTENSET: event_route_enable_q <= event_route_enable_q | reg_to_ev(hwdata_in);
				OFS_EVTENCLR: event_route_enable_q <= event_route_enable_q & ~reg_to_ev(hwdata_in);
				OFS_INTENSET: int_en_q <= int_en_q | reg_to_ev(hwdata_in);
				OFS_INTENCLR: int_en_q <= int_en_q & ~reg_to_ev(hwdata_in);
				default: begin
					if (wr_div) begin
						divider_q <= hwdata_in[DIV_W-1:0];
					end
					for (int i = 0; i < NUM_CMP; i++) begin
						if (wr_cmp[i]) begin
							compare_value_q[i] <= hwdata_in[COUNT_W-1:0];
						end
					end
				end
			endcase
		end
	end

	// Read mux at the address phase
	always_comb begin
		rd_mux = '0;
		unique case (haddr_in[11:0])
			OFS_EV_TICK:  rd_mux[0] = ev_flag_q[EV_TICK];
			OFS_EV_WRAP:  rd_mux[0] = ev_flag_q[EV_WRAP];
			OFS_INTENSET: rd_mux = ev_to_reg(int_en_q);
			OFS_INTENCLR: rd_mux = ev_to_reg(int_en_q);
			OFS_EVENT_ROUTE_ENABLE:    rd_mux = ev_to_reg(event_route_enable_q);
			OFS_EVTENSET: rd_mux = ev_to_reg(event_route_enable_q);
			OFS_EVTENCLR: rd_mux = ev_to_reg(event_route_enable_q);
			OFS_COUNTER:  rd_mux[COUNT_W-1:0] = count_q;
			OFS_DIVIDER:  rd_mux[DIV_W-1:0] = divider_q;
			default: begin
				for (int i = 0; i < NUM_CMP; i++) begin
					if (haddr_in[11:0] == OFS_CMP0 + 12'(4 * i)) begin
						rd_mux[COUNT_W-1:0] = compare_value_q[i];
					end
					if (haddr_in[11:0] == OFS_EV_CMP0 + 12'(4 * i)) begin
						rd_mux[0] = ev_flag_q[EV_CMP0 + i];
					end
				end
			end
		endcase
	end

	// Bus phase tracking and counter read stall
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			dp_wr_q   <= 1'b0;
			dp_addr_q <= '0;
			wait_q    <= '0;
			rdata_q   <= '0;
		end else if (hreadyout_out) begin
			dp_wr_q   <= ap_valid && hwrite_in;
			dp_addr_q <= haddr_in[11:0];
			if (ap_valid && !hwrite_in) begin
				rdata_q <= rd_mux;
			end
			// three stalled cycles on a counter read
			if (ap_valid && !hwrite_in && haddr_in[11:0] == OFS_COUNTER) begin
				wait_q <= CNT_RD_WAIT;
			end
		end else begin
			dp_wr_q <= 1'b0;
			wait_q  <= wait_q - 1'b1;
		end
	end

	// ready low while the stall counts down
	assign hreadyout_out = (wait_q == 2'h0);
	assign hresp_out     = 1'b0;
	assign hrdata_out    = rdata_q;
endmodule

/* test/lfrc_lf_source.sv */
// Behavioural low-frequency clock source that the counter depends on
`timescale 1ns/1ps
module lfrc_lf_source #(
	parameter int STARTUP = 400
) (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic on_in,
	input  wire logic request_in,
	output logic      stable_out
);
	logic req_q;
	int   warm_q;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) req_q <= 1'b0;
		else if (request_in) req_q <= 1'b1;
	end
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) warm_q <= 0;
		else if (!(on_in || req_q)) warm_q <= 0;
		else if (warm_q < STARTUP) warm_q <= warm_q + 1;
	end
	// Oscillator start-up: not stable until warmed up
	assign stable_out = (warm_q >= STARTUP);
endmodule

/* test/lfrc_top_checker.sv */
// Bus timing and event assertions for the low-frequency counter
`timescale 1ns/1ps
module lfrc_top_checker import lfrc_pkg::*; (
	input wire logic                        clk_sys_in,
	input wire logic                        rst_in,
	input wire logic                        hsel_in,
	input wire logic [31:0]                 haddr_in,
	input wire logic [1:0]                  htrans_in,
	input wire logic                        hwrite_in,
	input wire logic [31:0]                 hwdata_in,
	input wire logic                        hready_in,
	input wire logic                        hreadyout_out,
	input wire logic                        low_freq_clock_stable_in,
	input wire logic                        low_freq_clock_request_out,
	input wire logic [lfrc_pkg::NUM_EV-1:0] event_out,
	input wire logic                        fast_clock_request_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	logic take;
	logic fnw_wr_q;
	assign take = hsel_in && htrans_in[1] && hready_in && hreadyout_out;
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) fnw_wr_q <= 1'b0;
		else fnw_wr_q <= take && hwrite_in && haddr_in[11:0] == OFS_TASK_FNW;
	end
	property p_cnt_stall;
		take && !hwrite_in && haddr_in[11:0] == OFS_COUNTER |=>
			(!hreadyout_out)[*3] ##1 hreadyout_out;
	endproperty
	a_cnt_stall: assert property (p_cnt_stall) else $error("counter read stall wrong");
	property p_reg_nostall;
		take && haddr_in[11:0] != OFS_COUNTER |=> hreadyout_out;
	endproperty
	a_reg_nostall: assert property (p_reg_nostall) else $error("register access stalled");
	property p_ev_fcr;
		event_out != '0 |-> fast_clock_request_out;
	endproperty
	a_ev_fcr: assert property (p_ev_fcr) else $error("routed event without clock request");
	property p_fcr_pulse;
		fast_clock_request_out |=> !fast_clock_request_out;
	endproperty
	a_fcr_pulse: assert property (p_fcr_pulse) else $error("clock request not a pulse");
	property p_reset_quiet;
		$fell(rst_in) |-> (event_out == '0)[*8];
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("event routed after reset");
	property p_tick_gap;
		event_out[EV_TICK] |=> (!event_out[EV_TICK])[*8];
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("increments too close");
	property p_quiet_off;
		(!low_freq_clock_stable_in)[*4] |-> event_out == '0;
	endproperty
	a_quiet_off: assert property (p_quiet_off) else $error("event without slow clock");
	property p_fnw_req;
		fnw_wr_q && hwdata_in[0] && !low_freq_clock_stable_in |-> ##[1:3] low_freq_clock_request_out;
	endproperty
	a_fnw_req: assert property (p_fnw_req) else $error("near-wrap did not request clock");
endmodule
bind lfrc_top lfrc_top_checker i_chk (
	.clk_sys_in(clk_sys_in), .rst_in(rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
	.htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in),
	.hready_in(hready_in), .hreadyout_out(hreadyout_out),
	.low_freq_clock_stable_in(low_freq_clock_stable_in),
	.low_freq_clock_request_out(low_freq_clock_request_out), .event_out(event_out),
	.fast_clock_request_out(fast_clock_request_out)
);

/* test/tb.sv */
// Self-checking bench for the low-frequency counter
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
	import lfrc_pkg::*;
	localparam int LIMIT = 100000;
	localparam int T_NS  = 5;
	logic              clk_sys_in, rst_in, hsel, hwrite, hreadyout, stable, lf_req, lf_on;
	logic              hresp, irq;
	logic [31:0]       haddr, hwdata, hrdata;
	logic [1:0]        htrans;
	logic [NUM_EV-1:0] ev;
	int                num_errors, n_compared, n_tick, n_cmp0, n_cmp1, cyc, req_seen;
	lfrc_top i_dut (
		.clk_sys_in(clk_sys_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp),
		.low_freq_clock_stable_in(stable), .low_freq_clock_request_out(lf_req),
		.event_out(ev), .fast_clock_request_out(), .event_irq_out(irq)
	);
	lfrc_lf_source i_lf (.clk_in(clk_sys_in), .rst_in(rst_in), .on_in(lf_on),
		.request_in(lf_req), .stable_out(stable));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	function automatic int exp_stall(input logic [11:0] a);
		return (a == OFS_COUNTER) ? int'(CNT_RD_WAIT) : 0;
	endfunction
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Address phase held until ready, then data phase until ready
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output int st);
		st = 0;
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {20'h0, a};
		// No local limit: only the bench timeout ends a wait
		do @(negedge clk_sys_in); while (hreadyout !== 1'b1);
		@(posedge clk_sys_in);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(negedge clk_sys_in);
		while (hreadyout !== 1'b1) begin st++; @(negedge clk_sys_in); end
		rd = hrdata;
		@(posedge clk_sys_in);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		int s;
		bus(1'b1, a, d, r, s);
	endtask
	task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
		logic [31:0] r;
		int s;
		bus(1'b0, a, 32'h0, r, s);
		`CHK(nm, e, r)
		`CHK("stall", exp_stall(a), s)
		`CHK("resp", 1'b0, hresp)
	endtask
	// Interrupt level is looked at mid-cycle, clear of the write edge
	task automatic chk_irq(input logic e);
		@(negedge clk_sys_in);
		`CHK("irq", e, irq)
		@(posedge clk_sys_in);
	endtask
	task automatic wait_cnt(ref int c, input int tgt);
		int n;
		n = 0;
		while (c < tgt && n < 20000) begin @(posedge clk_sys_in); n++; end
	endtask
	initial begin clk_sys_in = 1'b0; forever #2.5 clk_sys_in = ~clk_sys_in; end
	always @(posedge clk_sys_in) begin
		cyc++;
		if (ev[EV_TICK] === 1'b1) n_tick++;
		if (ev[EV_CMP0] === 1'b1) n_cmp0++;
		if (ev[EV_CMP0 + 1] === 1'b1) n_cmp1++;
		if (lf_req === 1'b1) req_seen = 1;
		if (cyc == LIMIT) begin num_errors++; report_and_stop(); end
	end
	initial begin
		logic [31:0] seed, v;
		int s, t0, tk, dt;
		logic ok;
		seed = 32'hd63d;
		{hsel, hwrite, htrans, haddr, hwdata, lf_on} = '0;
		rst_in = 1'b1;
		repeat (8) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		@(posedge clk_sys_in);
		rd_chk("counter", OFS_COUNTER, 32'h0);
		rd_chk("unmapped", 12'hffc, 32'h0);
		seed = xs(seed);
		wr(OFS_DIVIDER, seed);
		rd_chk("divider", OFS_DIVIDER, seed & 32'hfff);
		for (int i = 0; i < NUM_CMP; i++) begin
			seed = xs(seed);
			wr(OFS_CMP0 + 12'(4 * i), seed);
			rd_chk("compare", OFS_CMP0 + 12'(4 * i), seed & 32'hffffff);
		end
		wr(OFS_COUNTER, 32'h55);
		rd_chk("counter ro", OFS_COUNTER, 32'h0);
		$display("end of test: registers");
		wr(OFS_DIVIDER, 32'h0);
		wr(OFS_CMP0, 32'h2);
		wr(OFS_CMP0 + 12'h4, 32'h0);
		wr(OFS_EVTENSET, 32'h3_0003);
		rd_chk("route", OFS_EVENT_ROUTE_ENABLE, 32'h3_0003);
		lf_on <= 1'b1;
		s = 0;
		while (stable !== 1'b1 && s < 1000) begin @(posedge clk_sys_in); s++; end
		t0 = cyc;
		wr(OFS_TASK_START, 32'h1);
		wr(OFS_DIVIDER, 32'h5);
		rd_chk("divider locked", OFS_DIVIDER, 32'h0);
		wait_cnt(n_tick, 1);
		dt = (cyc - t0) * T_NS;
		ok = (dt >= TASK_DLY_MIN_NS) && (dt <= TASK_DLY_MAX_NS + 100);
		`CHK("first tick", 1'b1, ok)
		wait_cnt(n_cmp0, 1);
		`CHK("ticks at match", 2, n_tick)
		rd_chk("count at match", OFS_COUNTER, 32'h2);
		$display("end of test: counting");
		wr(OFS_TASK_STOP, 32'h1);
		repeat (16000) @(posedge clk_sys_in);
		tk = n_tick;
		bus(1'b0, OFS_COUNTER, 32'h0, v, s);
		repeat (6200) @(posedge clk_sys_in);
		rd_chk("stopped count", OFS_COUNTER, v);
		`CHK("stopped ticks", tk, n_tick)
		rd_chk("tick flag", OFS_EV_TICK, 32'h1);
		wr(OFS_EV_TICK, 32'h0);
		rd_chk("tick flag clear", OFS_EV_TICK, 32'h0);
		chk_irq(1'b0);
		wr(OFS_EV_TICK, 32'h1);
		wr(OFS_INTENSET, 32'h1);
		rd_chk("irq enable", OFS_INTENSET, 32'h1);
		chk_irq(1'b1);
		wr(OFS_INTENCLR, 32'h1);
		chk_irq(1'b0);
		wr(OFS_TASK_CLEAR, 32'h1);
		repeat (16000) @(posedge clk_sys_in);
		rd_chk("cleared", OFS_COUNTER, 32'h0);
		`CHK("zero compare on clear", 0, n_cmp1)
		tk = n_tick;
		wr(OFS_TASK_START, 32'h1);
		wait_cnt(n_tick, tk + 1);
		`CHK("compare on start", 0, n_cmp1)
		$display("end of test: stop and clear");
		lf_on <= 1'b0;
		repeat (20) @(posedge clk_sys_in);
		wr(OFS_TASK_FNW, 32'h1);
		repeat (18000) @(posedge clk_sys_in);
		`CHK("clock request", 1, req_seen)
		bus(1'b0, OFS_COUNTER, 32'h0, v, s);
		`CHK("near wrap", 20'hfffff, v[23:4])
		$display("end of test: near wrap");
		report_and_stop();
	end
endmodule
